/* File: verification/pcrc_engine_test.sv */
// Self-checking bench for the programmable CRC engine
`timescale 1ns/1ps
module pcrc_engine_test;
   import pcrc_pkg::*;
   logic clk;
   logic rst_b;
   logic idleMode;
   pcrc_bus_type busReq;
   logic [15:0] rdData_ff;
   logic irq_ff;
   int numErrors;
   int checkCount;
   int dwT[3] = '{7, 12, 31};
   int plT[3] = '{15, 15, 31};
   int nT[3] = '{4, 9, 4};
   int depth;
   int wid;
   logic [31:0] lfsr;
   logic [15:0] rv;
   logic [15:0] con1;
   logic [15:0] e;
   logic [15:0] xl;
   logic [15:0] xh;
   logic [31:0] crc;
   logic [31:0] poly;
   logic [31:0] w;
   logic [31:0] q[$];

   pcrc_engine dut (
      .clk(clk),
      .rst_b(rst_b),
      .busReq(busReq),
      .rdData_ff(rdData_ff),
      .idleMode(idleMode),
      .irq_ff(irq_ff)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic testDone();
      $display("checks %0d mismatches %0d", checkCount, numErrors);
      if (numErrors == 0 && checkCount > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         numErrors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [31:0] lfsrNext(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic rnd();
      lfsr = lfsrNext(lfsr);
      rv = lfsr[15:0];
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask

   // Read data is valid only in the cycle after the strobe, so sample mid-cycle
   task automatic rdChk(input logic [3:0] a, input logic [15:0] exp, input string what);
      logic [15:0] d;
      @(posedge clk);
      busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      busReq.rd <= 1'b0;
      @(negedge clk);
      d = rdData_ff;
      check(what, {16'h0000, d}, {16'h0000, exp});
   endtask

   task automatic waitIrq();
      int n;
      n = 0;
      while (irq_ff !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (n >= 400) begin
         numErrors++;
         $display("wrong value irq wait expected 1 seen timeout");
         testDone();
      end
   endtask

   // Reference shifter: one bit per step, taps above the length masked off
   function automatic logic [31:0] crcWord(input logic [31:0] c, input logic [31:0] x,
      input int wd, input int pl, input logic [31:0] p, input logic lsb);
      logic fb;
      for (int k = 0; k < wd; k++) begin
         fb = c[pl] ^ (lsb ? x[k] : x[wd-1-k]);
         c = ((c << 1) ^ (fb ? p : 32'h0000_0000)) | {31'h0000_0000, fb};
         c = c & (32'hFFFF_FFFF >> (31 - pl));
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b = 1'b0;
      idleMode = 1'b0;
      busReq = '0;
      lfsr = 32'h7E2F24E7;
      numErrors = 0;
      checkCount = 0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      for (int a = 0; a < 12; a++) begin
         rdChk(a[3:0], (a == 0) ? CON1_RST : REG_RST, "reset value");
      end
      for (int i = 0; i < 4; i++) begin
         rnd();
         wr(REG_CON2, rv);
         rdChk(REG_CON2, rv & 16'h1F1F, "control two");
         wr(REG_XORL, ~rv);
         rdChk(REG_XORL, ~rv & 16'hFFFE, "terms low");
         wr(REG_XORH, rv);
         rdChk(REG_XORH, rv, "terms high");
         wr(4'hB, rv);
         rdChk(4'hB, 16'h0000, "unmapped");
      end
      wr(REG_IRQEN, 16'h0001);
      // Words are queued with the shifter stopped so the count only drains at the end
      for (int r = 0; r < 3; r++) begin
         wid = dwT[r] + 1;
         depth = (wid > 16) ? 4 : (wid > 8) ? 8 : 16;
         rnd();
         xl = rv & 16'hFFFE;
         rnd();
         xh = rv;
         poly = {xh, xl};
         con1 = {1'b1, 1'b0, r == 0, 7'h00, r == 2, 1'b0, r == 1, 3'h0};
         wr(REG_CON2, {3'h0, 5'(dwT[r]), 3'h0, 5'(plT[r])});
         wr(REG_XORL, xl);
         wr(REG_XORH, xh);
         wr(REG_CON1, con1);
         rnd();
         crc = {rv, rv} & (32'hFFFF_FFFF >> (31 - plT[r]));
         wr(REG_WDATL, rv);
         wr(REG_WDATH, rv);
         wr(REG_IRQCLR, 16'h0003);
         q.delete();
         for (int i = 0; i < nT[r]; i++) begin
            rnd();
            w = {lfsr[31:16], rv};
            wr(REG_DATL, w[15:0]);
            if (wid > 16) begin
               if (i == 0) begin
                  rdChk(REG_CON1, con1 | 16'h0040, "low half only");
               end
               wr(REG_DATH, w[31:16]);
            end
            if (q.size() < depth) begin
               q.push_back(w & (32'hFFFF_FFFF >> (32 - wid)));
            end
         end
         e = con1 | 16'(q.size() << 8) | ((q.size() == depth) ? 16'h0080 : 16'h0000);
         rdChk(REG_CON1, e, "word count");
         rdChk(REG_IRQST, (q.size() == depth) ? 16'h0002 : 16'h0000, "full event");
         @(posedge clk);
         // The second pass runs in idle with stop-in-idle clear and must still finish
         idleMode <= (r != 2);
         wr(REG_CON1, con1 | 16'h0010);
         if (r == 0) begin
            repeat (20) @(posedge clk);
            rdChk(REG_CON1, e | 16'h0010, "frozen in idle");
            @(posedge clk);
            idleMode <= 1'b0;
         end
         foreach (q[i]) begin
            crc = crcWord(crc, q[i], wid, plT[r], poly, con1[3]);
         end
         waitIrq();
         if (r == 2) begin
            rdChk(REG_CON1, 16'h8070, "early event");
            repeat (20) @(posedge clk);
         end else begin
            rdChk(REG_CON1, con1 | 16'h0040, "run cleared");
         end
         rdChk(REG_WDATL, crc[15:0], "result low");
         rdChk(REG_WDATH, crc[31:16], "result high");
      end
      wr(REG_IRQEN, 16'h0000);
      repeat (2) @(negedge clk);
      check("irq masked", {31'h0, irq_ff}, 32'h0);
      rdChk(REG_IRQST, 16'h0003, "sticky status");
      wr(REG_IRQEN, 16'h0001);
      repeat (2) @(negedge clk);
      check("irq enabled", {31'h0, irq_ff}, 32'h1);
      wr(REG_IRQCLR, 16'h0001);
      repeat (2) @(negedge clk);
      check("irq cleared", {31'h0, irq_ff}, 32'h0);
      rdChk(REG_IRQST, 16'h0002, "after clear");
      wr(REG_CON2, 16'h0707);
      wr(REG_CON1, 16'h8000);
      wr(REG_DATH, 16'h1234);
      wr(REG_DATL, 16'h0055);
      wr(REG_WDATL, 16'hBEEF);
      wr(REG_CON1, 16'h0000);
      rdChk(REG_CON1, 16'h0040, "disabled");
      rdChk(REG_WDATL, 16'h0000, "result flushed");
      rdChk(REG_DATH, 16'h0000, "upper flushed");
      rdChk(REG_CON2, 16'h0707, "control kept");
      rdChk(REG_XORL, xl, "terms kept");
      wr(REG_CON1, 16'h8000);
      rdChk(REG_CON1, 16'h8040, "fifo flushed");
      testDone();
   end
endmodule // pcrc_engine_test

/* File: verilog/pcrc_engine.sv */
// Programmable CRC engine: registers, serial shifter and interrupt
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
module pcrc_engine
   import pcrc_pkg::*;
#(
   parameter int MAX_DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire pcrc_bus_type busReq,
   output logic [15:0] rdData_ff,
   // Power state and interrupt
   input wire logic idleMode,
   output logic irq_ff
);
   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic hit(pcrc_bus_type b, logic [ADDR_W-1:0] a);
      return b.wr && (b.addr == a);
   endfunction

   function automatic logic [CNT_W-1:0] depthOf(logic [4:0] dw);
      if (dw >= DW_WIDE_MIN) begin
         return DEPTH_WIDE;
      end else if (dw >= DW_MID_MIN) begin
         return DEPTH_MID;
      end
      return DEPTH_NARROW;
   endfunction

   function automatic logic pickBit(logic [31:0] w, logic [5:0] idx, logic [4:0] dw,
                                    logic lsb);
      logic [4:0] pos;
      pos = lsb ? idx[4:0] : dw - idx[4:0];
      return w[pos];
   endfunction

   // One Galois step; bits above the polynomial length are kept clear
   function automatic logic [31:0] crcStep(logic [31:0] c, logic d, logic [31:0] p,
                                           logic [4:0] pl);
      logic fb;
      logic [31:0] r;
      fb = c[pl] ^ d;
      r = {c[30:0], fb} ^ ({32{fb}} & {p[31:1], 1'b0});
      return r & (32'hFFFF_FFFF >> (5'h1F - pl));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   pcrc_ctrl_type ctrl_ff, nxtCtrl;
   pcrc_cfg_type cfg_ff, nxtCfg;
   pcrc_state_type state_ff, nxtState;
   logic [15:1] polyLo_ff, nxtPolyLo;
   logic [15:0] polyHi_ff, nxtPolyHi;
   logic [15:0] datLo_ff, nxtDatLo;
   logic [15:0] datHi_ff, nxtDatHi;
   logic [31:0] crc_ff, nxtCrc;
   logic [31:0] buf_ff, nxtBuf;
   logic [5:0] bitCnt_ff, nxtBitCnt;
   logic [1:0] irqSt_ff, nxtIrqSt;
   logic [1:0] irqEn_ff, nxtIrqEn;
   logic fullPrev_ff;
   logic [15:0] nxtRd;
   logic nxtIrq;
   logic [31:0] poly;
   logic [5:0] wordBits;
   logic halt, wide, shiftDone;
   logic pushVal, pushRdy, pushAcc, popVld, popGo;
   logic [31:0] pushData, popData;
   logic [CNT_W-1:0] fifoCount, limit;
   logic fullNow, emptyNow;
   logic evRunEnd, evLastPop;
   logic [1:0] ev, clrMask;

   ////////////////////////////////////////////////////////////////////////////
   // Data path into the FIFO

   assign poly = {polyHi_ff, polyLo_ff, 1'b0};
   assign wordBits = {1'b0, cfg_ff.dw} + 6'h01;
   assign halt = ctrl_ff.sidl && idleMode;
   assign wide = cfg_ff.dw >= DW_WIDE_MIN;
   assign limit = depthOf(cfg_ff.dw);

   // The word counts once its top byte lands, so the low half must lead
   assign pushVal = ctrl_ff.en && (wide ? hit(busReq, REG_DATH) : hit(busReq, REG_DATL));
   assign pushData = wide ? {busReq.wdata, datLo_ff} : {datHi_ff, busReq.wdata};
   assign pushAcc = pushVal && pushRdy;
   assign popGo = ctrl_ff.en && !halt && ctrl_ff.run && popVld
                  && (state_ff == PCRC_IDLE);
   assign fullNow = fifoCount >= limit;
   assign emptyNow = fifoCount == '0;

   pcrc_fifo #(
      .WIDTH(32),
      .DEPTH(MAX_DEPTH)
   ) wordFifo (
      .clk(clk),
      .rst_b(rst_b),
      .flush(!ctrl_ff.en),
      .limit(limit),
      .pushValid(pushVal),
      .pushData(pushData),
      .pushReady(pushRdy),
      .popReady(popGo),
      .popValid(popVld),
      .popData(popData),
      .count(fifoCount)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Serial shifter

   always_comb begin
      nxtState = state_ff;
      nxtBuf = buf_ff;
      nxtBitCnt = bitCnt_ff;
      nxtCrc = crc_ff;
      shiftDone = 1'b0;
      // A seed written mid-word is overtaken by the shift of that cycle
      if (hit(busReq, REG_WDATL)) begin
         nxtCrc[15:0] = busReq.wdata;
      end
      if (hit(busReq, REG_WDATH)) begin
         nxtCrc[31:16] = busReq.wdata;
      end
      if (!halt) begin
         case (state_ff)
            PCRC_IDLE: begin
               if (popGo) begin
                  nxtBuf = popData;
                  nxtBitCnt = 6'h00;
                  nxtState = PCRC_SHIFT;
               end
            end
            PCRC_SHIFT: begin
               nxtCrc = crcStep(crc_ff, pickBit(buf_ff, bitCnt_ff, cfg_ff.dw, ctrl_ff.lsb),
                                poly, cfg_ff.pl);
               if (bitCnt_ff + 6'h01 < wordBits) begin
                  nxtCrc = crcStep(nxtCrc, pickBit(buf_ff, bitCnt_ff + 6'h01, cfg_ff.dw,
                                   ctrl_ff.lsb), poly, cfg_ff.pl);
               end
               if (bitCnt_ff + 6'h02 >= wordBits) begin
                  shiftDone = 1'b1;
                  nxtState = PCRC_IDLE;
               end else begin
                  nxtBitCnt = bitCnt_ff + 6'h02;
               end
            end
            default: begin
               nxtState = PCRC_IDLE;
            end
         endcase
      end
      if (!ctrl_ff.en) begin
         nxtState = PCRC_IDLE;
         nxtBitCnt = 6'h00;
         nxtCrc = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= PCRC_IDLE;
         buf_ff <= '0;
         bitCnt_ff <= 6'h00;
         crc_ff <= '0;
      end else begin
         state_ff <= nxtState;
         buf_ff <= nxtBuf;
         bitCnt_ff <= nxtBitCnt;
         crc_ff <= nxtCrc;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers and events

   assign evRunEnd = shiftDone && emptyNow && !pushAcc;
   assign evLastPop = popGo && (fifoCount == 5'h01) && !pushAcc;
   assign ev[IRQ_DONE] = ctrl_ff.isel ? evLastPop : evRunEnd;
   assign ev[IRQ_FULL] = fullNow && !fullPrev_ff;
   assign clrMask = hit(busReq, REG_IRQCLR) ? busReq.wdata[1:0] : 2'h0;

   always_comb begin
      nxtCtrl = ctrl_ff;
      nxtCfg = cfg_ff;
      nxtPolyLo = polyLo_ff;
      nxtPolyHi = polyHi_ff;
      nxtDatLo = datLo_ff;
      nxtDatHi = datHi_ff;
      nxtIrqEn = irqEn_ff;
      // Hardware ends the run, but a software write of the same cycle wins
      if (evRunEnd) begin
         nxtCtrl.run = 1'b0;
      end
      if (hit(busReq, REG_CON1)) begin
         nxtCtrl.en = busReq.wdata[CON1_EN];
         nxtCtrl.sidl = busReq.wdata[CON1_SIDL];
         nxtCtrl.isel = busReq.wdata[CON1_ISEL];
         nxtCtrl.run = busReq.wdata[CON1_GO];
         nxtCtrl.lsb = busReq.wdata[CON1_LSB];
      end
      if (hit(busReq, REG_CON2)) begin
         nxtCfg.dw = busReq.wdata[CON2_DW +: 5];
         nxtCfg.pl = busReq.wdata[CON2_PL +: 5];
      end
      if (hit(busReq, REG_XORL)) begin
         nxtPolyLo = busReq.wdata[15:1];
      end
      if (hit(busReq, REG_XORH)) begin
         nxtPolyHi = busReq.wdata;
      end
      if (hit(busReq, REG_DATL)) begin
         nxtDatLo = busReq.wdata;
      end
      if (hit(busReq, REG_DATH)) begin
         nxtDatHi = busReq.wdata;
      end
      if (!ctrl_ff.en) begin
         nxtDatHi = '0;
      end
      if (hit(busReq, REG_IRQEN)) begin
         nxtIrqEn = busReq.wdata[1:0];
      end
      // Set wins over a clear in the same cycle
      nxtIrqSt = (irqSt_ff & ~clrMask) | ev;
      nxtIrq = |(nxtIrqSt & nxtIrqEn);
   end

   always_comb begin
      nxtRd = REG_RST;
      if (busReq.rd) begin
         case (busReq.addr)
            REG_CON1: begin
               nxtRd[CON1_EN] = ctrl_ff.en;
               nxtRd[CON1_SIDL] = ctrl_ff.sidl;
               nxtRd[CON1_VW +: 5] = fifoCount;
               nxtRd[CON1_FUL] = fullNow;
               nxtRd[CON1_MPT] = emptyNow;
               nxtRd[CON1_ISEL] = ctrl_ff.isel;
               nxtRd[CON1_GO] = ctrl_ff.run;
               nxtRd[CON1_LSB] = ctrl_ff.lsb;
            end
            REG_CON2: begin
               nxtRd[CON2_DW +: 5] = cfg_ff.dw;
               nxtRd[CON2_PL +: 5] = cfg_ff.pl;
            end
            REG_XORL: nxtRd = {polyLo_ff, 1'b0};
            REG_XORH: nxtRd = polyHi_ff;
            REG_DATL: nxtRd = datLo_ff;
            REG_DATH: nxtRd = datHi_ff;
            REG_WDATL: nxtRd = crc_ff[15:0];
            REG_WDATH: nxtRd = crc_ff[31:16];
            REG_IRQST: nxtRd = {14'h0000, irqSt_ff};
            REG_IRQEN: nxtRd = {14'h0000, irqEn_ff};
            default: nxtRd = REG_RST;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= '0;
         cfg_ff <= '0;
         polyLo_ff <= '0;
         polyHi_ff <= REG_RST;
         datLo_ff <= REG_RST;
         datHi_ff <= REG_RST;
         irqSt_ff <= 2'h0;
         irqEn_ff <= 2'h0;
         fullPrev_ff <= 1'b0;
         rdData_ff <= REG_RST;
         irq_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxtCtrl;
         cfg_ff <= nxtCfg;
         polyLo_ff <= nxtPolyLo;
         polyHi_ff <= nxtPolyHi;
         datLo_ff <= nxtDatLo;
         datHi_ff <= nxtDatHi;
         irqSt_ff <= nxtIrqSt;
         irqEn_ff <= nxtIrqEn;
         fullPrev_ff <= fullNow;
         rdData_ff <= nxtRd;
         irq_ff <= nxtIrq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence sLoad;
      popGo && !pushAcc;
   endsequence

   sequence sFirstPair;
      state_ff == PCRC_SHIFT && bitCnt_ff == 6'h00;
   endsequence

   chk_enable_flush:
      assert property (!ctrl_ff.en |=> fifoCount == '0 && state_ff == PCRC_IDLE
                       && crc_ff == '0 && datHi_ff == '0)
      else $error("Disable did not flush the engine");

   chk_idle_freeze:
      assert property (halt && ctrl_ff.en && !busReq.wr |=> $stable(crc_ff)
                       && $stable(bitCnt_ff) && $stable(fifoCount))
      else $error("Engine moved while halted in idle");

   chk_full_flag:
      assert property (pushAcc && !popGo && fifoCount == limit - 5'h01
                       && !hit(busReq, REG_CON2) |=> fullNow ##1 1'b1)
      else $error("Full flag missing at depth");

   chk_empty_flag:
      assert property (sLoad and evLastPop |=> emptyNow && !fullNow)
      else $error("Empty flag missing after last load");

   chk_irq_source:
      assert property (ev[IRQ_DONE] |=> irqSt_ff[IRQ_DONE] && (irq_ff || !irqEn_ff[IRQ_DONE]))
      else $error("Done event not latched or not signalled");

   chk_run_clear:
      assert property (evRunEnd && !hit(busReq, REG_CON1) |=> !ctrl_ff.run)
      else $error("Run bit not cleared at end");

   chk_load_start:
      assert property (sLoad |=> sFirstPair and fifoCount == $past(fifoCount) - 5'h01)
      else $error("Load did not start shifting");

   chk_two_bits:
      assert property (sFirstPair and (!halt && ctrl_ff.en && !busReq.wr && wordBits > 6'h04)
                       |=> bitCnt_ff == 6'h02 ##1 (halt || bitCnt_ff == 6'h04))
      else $error("Shifter not advancing two bits per cycle");

   chk_push_count:
      assert property (pushAcc && !popGo && ctrl_ff.en
                       |=> fifoCount == $past(fifoCount) + 5'h01)
      else $error("Count did not rise on push");
endmodule // pcrc_engine

/* File: verilog/pcrc_fifo.sv */
// Word FIFO with a run-time occupancy limit for the CRC engine
`timescale 1ns/1ps
module pcrc_fifo
   import pcrc_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic flush,
   input wire logic [CNT_W-1:0] limit,
   // Fill side
   input wire logic pushValid,
   input wire logic [WIDTH-1:0] pushData,
   output logic pushReady,
   // Drain side
   input wire logic popReady,
   output logic popValid,
   output logic [WIDTH-1:0] popData,
   output logic [CNT_W-1:0] count
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wrPtr_ff, rdPtr_ff, nxtWrPtr, nxtRdPtr;
   logic [CNT_W-1:0] count_ff, nxtCount;
   logic doPush, doPop;

   // Limit may shrink below the count; push stays refused until it drains
   assign pushReady = count_ff < limit;
   assign popValid = count_ff != '0;
   assign popData = mem[rdPtr_ff];
   assign count = count_ff;
   assign doPush = pushValid && pushReady;
   assign doPop = popReady && popValid;

   always_comb begin
      nxtWrPtr = wrPtr_ff + PTR_W'(doPush);
      nxtRdPtr = rdPtr_ff + PTR_W'(doPop);
      nxtCount = count_ff + CNT_W'(doPush) - CNT_W'(doPop);
      if (flush) begin
         nxtWrPtr = '0;
         nxtRdPtr = '0;
         nxtCount = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         wrPtr_ff <= nxtWrPtr;
         rdPtr_ff <= nxtRdPtr;
         count_ff <= nxtCount;
      end
   end

   // Storage needs no reset; the count guards every read
   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr_ff] <= pushData;
      end
   end
endmodule // pcrc_fifo

/* File: verilog/pcrc_pkg.sv */
// Constants, types and rule summary for the programmable CRC engine
// How it works
// - Clearing enable stops engine, flushes FIFO, clears result and upper data word.
// - With stop-in-idle set, the engine freezes while the device idles.
// - Read-only valid word count shows FIFO occupancy, up to its depth.
// - Full flag reads one while the count is at or above the FIFO depth.
// - Empty flag reads one exactly while the count is zero; resets to one.
// - Select set: interrupt as last word leaves FIFO; clear: when shifting completes.
// - Software sets or clears the run bit; hardware clears it when work ends.
// - LSB-first select feeds each word low bit first, else high bit first.
// - Data width field holds word width minus one and sets bits per word.
// - Polynomial length field holds length minus one, the highest exponent used.
// - Low term register enables x^15..x^1; bit 0 reads zero.
// - High term register enables x^31..x^16 feedback taps.
// - FIFO depth is 4, 8 or 16 words depending on data width.
// - Shifting starts with run set and words present; each load decrements count.
// - Two data bits enter the CRC per clock until the FIFO is drained.
// - Count rises when the word's top bit is written; low half goes first.
package pcrc_pkg;
   localparam int ADDR_W = 4;
   localparam int CNT_W = 5;
   // Register indices
   localparam logic [3:0] REG_CON1 = 4'h0;
   localparam logic [3:0] REG_CON2 = 4'h1;
   localparam logic [3:0] REG_XORL = 4'h2;
   localparam logic [3:0] REG_XORH = 4'h3;
   localparam logic [3:0] REG_DATL = 4'h4;
   localparam logic [3:0] REG_DATH = 4'h5;
   localparam logic [3:0] REG_WDATL = 4'h6;
   localparam logic [3:0] REG_WDATH = 4'h7;
   localparam logic [3:0] REG_IRQST = 4'h8;
   localparam logic [3:0] REG_IRQEN = 4'h9;
   localparam logic [3:0] REG_IRQCLR = 4'hA;
   // Field positions
   localparam int CON1_EN = 15;
   localparam int CON1_SIDL = 13;
   localparam int CON1_VW = 8;
   localparam int CON1_FUL = 7;
   localparam int CON1_MPT = 6;
   localparam int CON1_ISEL = 5;
   localparam int CON1_GO = 4;
   localparam int CON1_LSB = 3;
   localparam int CON2_DW = 8;
   localparam int CON2_PL = 0;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FULL = 1;
   // Reset values
   localparam logic [15:0] CON1_RST = 16'h0040;
   localparam logic [15:0] REG_RST = 16'h0000;
   // FIFO depth selection by data width field
   localparam logic [4:0] DW_WIDE_MIN = 5'h10;
   localparam logic [4:0] DW_MID_MIN = 5'h08;
   localparam logic [4:0] DEPTH_WIDE = 5'h04;
   localparam logic [4:0] DEPTH_MID = 5'h08;
   localparam logic [4:0] DEPTH_NARROW = 5'h10;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } pcrc_bus_type;

   typedef struct packed {
      logic en;
      logic sidl;
      logic isel;
      logic run;
      logic lsb;
   } pcrc_ctrl_type;

   typedef struct packed {
      logic [4:0] dw;
      logic [4:0] pl;
   } pcrc_cfg_type;

   typedef enum logic [0:0] {
      PCRC_IDLE = 1'b0,
      PCRC_SHIFT = 1'b1
   } pcrc_state_type;
endpackage
